// ---- adc12_sequencer_control_tb_top.sv ----
// testbench: register access, reference and pin split, conversion timing and abort
`timescale 1ns/1ps
module adc12_sequencer_control_tb_top;
  import adcsq_pkg::*;

  //------------------------------------------------------------
  // signals
  //------------------------------------------------------------
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        strap   = 1'b1;
  logic [11:0] sar     = 12'hABC;
  logic [11:0] last_sar;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [12:0] pin_analog_en;
  logic        hreadyout;
  logic        hresp;
  logic        neg_ref_ext;
  logic        pos_ref_ext;
  logic        sample_en;
  logic        conv_irq;
  int          miscompares = 0;
  int          checks_done = 0;
  int          div_tab [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int          acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  adcsq_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .portb_analog_default(strap),
    .sar_result(sar), .neg_ref_ext(neg_ref_ext), .pos_ref_ext(pos_ref_ext),
    .pin_analog_en(pin_analog_en), .sample_en(sample_en), .conv_irq(conv_irq)
  );

  always #10 hclk = ~hclk;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one single transfer: address phase, then data phase, each held until hready
  task automatic ahb(input logic is_wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= is_wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= is_wr ? wd : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdc

  task automatic span(input int cnt, input int lo, input int hi, input string what);
    chk(32'(cnt >= lo && cnt <= hi), 32'h1, what);
  endtask : span

  task automatic wait_for(input logic lvl, input bit use_irq, output int n);
    n = 0;
    while (((use_irq ? conv_irq : sample_en) !== lvl) && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 5000) begin
      miscompares++;
      $display("Error at %0t: wait limit reached", $time);
    end
  endtask : wait_for

  task automatic do_reset(input logic s);
    @(posedge hclk);
    hresetn <= 1'b0;
    strap   <= s;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : do_reset

  function automatic logic [31:0] amask(input int c);
    return (c <= 2) ? 32'h1FFF : 32'h1FFF >> (c - 2);
  endfunction : amask

  // full conversion with irq enabled, timing measured at the pins
  task automatic convert(input logic [7:0] fmt, input logic [11:0] sv);
    int t, n, lo, hi;
    bit rc;
    t  = div_tab[fmt[2:0]];
    rc = (t == 0);
    if (rc) begin
      t = RC_DIV;
    end
    lo  = acq_tab[fmt[5:3]] * t + (rc ? TCY_OSC : 0);
    hi  = lo + t + 3;
    sar <= sv;
    wr(ADDR_FMT_TIMING, {24'h0, fmt});
    wr(ADDR_STATUS, 32'h2);
    if (fmt[5:3] == 3'h0) begin
      repeat (2 * t) @(posedge hclk);
    end
    wr(ADDR_CHAN_CTRL, 32'h3);
    wait_for(1'b0, 1'b0, n);
    span(n, lo, hi, "acquisition span");
    wait_for(1'b1, 1'b1, n);
    span(n, 13 * t - 2, 14 * t + 3, "conversion span");
    wait_for(1'b1, 1'b0, n);
    span(n, 2 * t - 2, 3 * t + 3, "gap span");
    rdc(ADDR_STATUS, 32'h3, "done flag");
    rdc(ADDR_CHAN_CTRL, 32'h1, "go cleared");
    rdc(ADDR_RES_HIGH, fmt[7] ? {28'h0, sv[11:8]} : {24'h0, sv[11:4]}, "res high");
    rdc(ADDR_RES_LOW, fmt[7] ? {24'h0, sv[7:0]} : {24'h0, sv[3:0], 4'h0}, "res low");
    wr(ADDR_STATUS, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, conv_irq}, 32'h0, "irq cleared");
    last_sar = sv;
  endtask : convert

  //------------------------------------------------------------
  // tests
  //------------------------------------------------------------
  initial begin
    int n;
    do_reset(1'b1);
    rdc(ADDR_REF_PIN, 32'h0, "por pin config");
    chk({19'h0, pin_analog_en}, amask(0), "por pins");
    rdc(ADDR_FMT_TIMING, {24'h0, FMT_RESET}, "fmt reset");
    rdc(8'h20, 32'h0, "unmapped");
    wr(ADDR_REF_PIN, 32'hFF);
    rdc(ADDR_REF_PIN, 32'h3F, "ref reserved");
    chk({30'h0, neg_ref_ext, pos_ref_ext}, 32'h3, "refs on");
    wr(ADDR_REF_PIN, 32'h10);
    repeat (2) @(posedge hclk);
    chk({30'h0, neg_ref_ext, pos_ref_ext}, 32'h1, "pos only");
    wr(ADDR_REF_PIN, 32'h20);
    repeat (2) @(posedge hclk);
    chk({30'h0, neg_ref_ext, pos_ref_ext}, 32'h2, "neg only");
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_REF_PIN, 32'(c));
      repeat (2) @(posedge hclk);
      chk({19'h0, pin_analog_en}, amask(c), "pin split");
    end
    wr(ADDR_FMT_TIMING, 32'hFF);
    rdc(ADDR_FMT_TIMING, 32'hBF, "fmt reserved");
    wr(ADDR_CHAN_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, sample_en}, 32'h1, "sampling on");
    for (int a = 0; a < 8; a++) begin
      convert({1'b1, 1'b0, 3'(a), 3'h0}, 12'h123 + 12'(a * 291));
    end
    for (int c = 1; c < 8; c++) begin
      convert({2'h0, 3'h1, 3'(c)}, 12'hF0E - 12'(c * 273));
    end
    // abort mid-conversion: result and done flag must not move
    sar <= 12'h5A5;
    wr(ADDR_STATUS, 32'h2);
    wr(ADDR_CHAN_CTRL, 32'h3);
    wait_for(1'b0, 1'b0, n);
    repeat (200) @(posedge hclk);
    wr(ADDR_CHAN_CTRL, 32'h1);
    sar <= 12'h0F0;
    wait_for(1'b1, 1'b0, n);
    rdc(ADDR_CHAN_CTRL, 32'h1, "abort go");
    rdc(ADDR_STATUS, 32'h2, "abort no done");
    rdc(ADDR_RES_HIGH, {24'h0, last_sar[11:4]}, "abort high");
    rdc(ADDR_RES_LOW, {24'h0, last_sar[3:0], 4'h0}, "abort low");
    chk({31'h0, conv_irq}, 32'h0, "abort irq");
    wr(ADDR_RES_HIGH, 32'h1A5);
    rdc(ADDR_RES_HIGH, 32'hA5, "written high");
    wr(ADDR_RES_LOW, 32'h13C);
    rdc(ADDR_RES_LOW, 32'h3C, "written low");
    do_reset(1'b0);
    rdc(ADDR_REF_PIN, {28'h0, PCFG_POR_DIGITAL}, "por digital");
    chk({19'h0, pin_analog_en}, amask(7), "por digital pins");
    end_of_test();
  end

  initial begin
    #(20 * 30000);
    miscompares++;
    end_of_test();
  end

endmodule : adc12_sequencer_control_tb_top

// ---- adcsq_pkg.sv ----
// package: register map, field layouts and timing constants of the converter sequencer
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
package adcsq_pkg;

  //------------------------------------------------------------
  // register byte addresses
  //------------------------------------------------------------
  localparam logic [7:0] ADDR_CHAN_CTRL  = 8'h00; // adc_channel_control
  localparam logic [7:0] ADDR_REF_PIN    = 8'h04; // adc_ref_and_pin_config
  localparam logic [7:0] ADDR_FMT_TIMING = 8'h08; // adc_format_timing_config
  localparam logic [7:0] ADDR_RES_HIGH   = 8'h0C; // result_high
  localparam logic [7:0] ADDR_RES_LOW    = 8'h10; // result_low
  localparam logic [7:0] ADDR_STATUS     = 8'h14; // done flag and irq enable

  //------------------------------------------------------------
  // field positions
  //------------------------------------------------------------
  localparam int BIT_MOD_ON     = 0;
  localparam int BIT_GO         = 1;
  localparam int BIT_NEG_REF    = 5;
  localparam int BIT_POS_REF    = 4;
  localparam int BIT_JUSTIFY    = 7;
  localparam int BIT_DONE_FLAG  = 0;
  localparam int BIT_IRQ_EN     = 1;

  //------------------------------------------------------------
  // reset values and all-analog pin code
  //------------------------------------------------------------
  localparam logic [3:0] PCFG_POR_ANALOG  = 4'h0;
  localparam logic [3:0] PCFG_POR_DIGITAL = 4'h7;
  localparam logic [7:0] FMT_RESET        = 8'h00;
  localparam logic [3:0] PCFG_ALL_ANALOG  = 4'h2;

  //------------------------------------------------------------
  // timing
  //------------------------------------------------------------
  localparam int CONV_BITS      = 13; // conversion-bit periods per conversion
  localparam int POST_GAP_BITS  = 2;  // periods before next acquisition
  localparam int NUM_INPUTS     = 13;
  localparam int CLK_HZ         = 50_000_000;
  localparam int RC_PERIOD_NS   = 2500; // nominal internal RC period
  localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  localparam int RC_DIV         = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TCY_OSC        = 4;    // oscillator clocks per instruction cycle

  typedef enum logic [2:0] {
    ADCSQ_IDLE, ADCSQ_RC_HOLD, ADCSQ_ACQ, ADCSQ_CONV, ADCSQ_GAP
  } adcsq_state_e;

  typedef struct packed {
    logic        neg_ref_select;
    logic        pos_ref_select;
    logic [3:0]  pin_analog_config;
  } adcsq_refpin_s;

endpackage : adcsq_pkg

// ---- adcsq_top.sv ----
// top: AHB-Lite slave with converter sequencer control
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int RES_W = 12
) (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // strap and analog core
  input  wire logic                  portb_analog_default,
  input  wire logic [RES_W-1:0]      sar_result,
  output logic                       neg_ref_ext,
  output logic                       pos_ref_ext,
  output logic [NUM_INPUTS-1:0]      pin_analog_en,
  output logic                       sample_en,
  output logic                       conv_irq
);

  //------------------------------------------------------------
  // bus decode
  //------------------------------------------------------------
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        strap_done_r;
  logic        mod_on_r;
  logic        go_r;
  adcsq_refpin_s refpin_r;
  logic [7:0]  fmt_r;
  logic        done_flag_r;
  logic        irq_en_r;
  logic [15:0] result_r;
  adcsq_state_e state_r;
  logic [6:0]  div_cnt_r;
  logic [4:0]  step_r;
  logic [1:0]  rc_hold_r;
  logic [31:0] rdata_nxt;
  wire         addr_ph  = hsel & hready & htrans[1];
  wire         wr_now   = wr_pend_r;
  wire         wr_ctrl  = wr_now & (wr_addr_r == ADDR_CHAN_CTRL);
  wire         wr_refp  = wr_now & (wr_addr_r == ADDR_REF_PIN);
  wire         wr_fmt   = wr_now & (wr_addr_r == ADDR_FMT_TIMING);
  wire         wr_stat  = wr_now & (wr_addr_r == ADDR_STATUS);
  wire         wr_resh  = wr_now & (wr_addr_r == ADDR_RES_HIGH);
  wire         wr_resl  = wr_now & (wr_addr_r == ADDR_RES_LOW);
  wire [2:0]   acq_code = fmt_r[5:3];
  wire [2:0]   clk_code = fmt_r[2:0];
  wire         use_rc   = (clk_code[1:0] == 2'b11);

  //------------------------------------------------------------
  // conversion-bit clock enable
  //------------------------------------------------------------
  logic [6:0] div_max;
  always_comb begin
    case (clk_code)
      3'h0:    div_max = 7'd1;
      3'h1:    div_max = 7'd7;
      3'h2:    div_max = 7'd31;
      3'h4:    div_max = 7'd3;
      3'h5:    div_max = 7'd15;
      3'h6:    div_max = 7'd63;
      default: div_max = 7'(RC_DIV - 1);
    endcase
  end
  wire tad_tick = (div_cnt_r == div_max);

  logic [4:0] acq_bits;
  always_comb begin
    case (acq_code)
      3'h0:    acq_bits = 5'd0;
      3'h1:    acq_bits = 5'd2;
      3'h2:    acq_bits = 5'd4;
      3'h3:    acq_bits = 5'd6;
      3'h4:    acq_bits = 5'd8;
      3'h5:    acq_bits = 5'd12;
      3'h6:    acq_bits = 5'd16;
      default: acq_bits = 5'd20;
    endcase
  end

  //------------------------------------------------------------
  // registers and AHB write path
  //------------------------------------------------------------
  wire go_clear_sw = wr_ctrl & ~hwdata[BIT_GO];
  wire go_set_sw   = wr_ctrl & hwdata[BIT_GO] & hwdata[BIT_MOD_ON];
  // an abort in the last step wins: no result capture, no done flag
  wire conv_last   = (state_r == ADCSQ_CONV) & tad_tick & ~go_clear_sw &
                     (step_r == 5'(CONV_BITS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ph & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_r <= 1'b0;
      refpin_r     <= '0;
      fmt_r        <= FMT_RESET;
      mod_on_r     <= 1'b0;
      irq_en_r     <= 1'b0;
    end else begin
      if (!strap_done_r) begin
        strap_done_r               <= 1'b1;
        refpin_r.pin_analog_config <= portb_analog_default ? PCFG_POR_ANALOG
                                                           : PCFG_POR_DIGITAL;
      end else if (wr_refp) begin
        refpin_r <= {hwdata[BIT_NEG_REF], hwdata[BIT_POS_REF], hwdata[3:0]};
      end
      if (wr_fmt)
        fmt_r <= {hwdata[BIT_JUSTIFY], 1'b0, hwdata[5:0]};
      if (wr_ctrl)
        mod_on_r <= hwdata[BIT_MOD_ON];
      if (wr_stat)
        irq_en_r <= hwdata[BIT_IRQ_EN];
    end
  end

  // done flag: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      done_flag_r <= 1'b0;
    else if (conv_last)
      done_flag_r <= 1'b1;
    else if (wr_stat)
      done_flag_r <= hwdata[BIT_DONE_FLAG];
  end

  // result pair has no reset: contents undefined at power-on
  always_ff @(posedge hclk) begin
    if (conv_last)
      result_r <= fmt_r[BIT_JUSTIFY] ? {4'h0, sar_result}
                                     : {sar_result, 4'h0};
    else if (wr_resh)
      result_r[15:8] <= hwdata[7:0];
    else if (wr_resl)
      result_r[7:0] <= hwdata[7:0];
  end

  //------------------------------------------------------------
  // sequencer
  //------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r   <= ADCSQ_IDLE;
      go_r      <= 1'b0;
      div_cnt_r <= 7'h00;
      step_r    <= 5'h00;
      rc_hold_r <= 2'h0;
    end else begin
      // divider held during rc holdoff so the conversion clock really starts late
      div_cnt_r <= (tad_tick || state_r == ADCSQ_IDLE || state_r == ADCSQ_RC_HOLD) ?
                   7'h00 : div_cnt_r + 7'h01;
      case (state_r)
        ADCSQ_IDLE: begin
          step_r <= 5'h00;
          if (go_set_sw) begin
            go_r <= 1'b1;
            if (use_rc) begin
              rc_hold_r <= 2'(TCY_OSC - 1);
              state_r   <= ADCSQ_RC_HOLD;
            end else if (acq_bits != 5'd0)
              state_r <= ADCSQ_ACQ;
            else
              state_r <= ADCSQ_CONV;
          end
        end
        ADCSQ_RC_HOLD: begin
          rc_hold_r <= rc_hold_r - 2'h1;
          if (go_clear_sw) begin
            go_r    <= 1'b0;
            state_r <= ADCSQ_IDLE;
          end else if (rc_hold_r == 2'h0)
            state_r <= (acq_bits != 5'd0) ? ADCSQ_ACQ : ADCSQ_CONV;
        end
        ADCSQ_ACQ: begin
          if (go_clear_sw) begin
            go_r    <= 1'b0;
            state_r <= ADCSQ_IDLE;
          end else if (tad_tick) begin
            step_r <= step_r + 5'h01;
            if (step_r == acq_bits - 5'd1) begin
              step_r  <= 5'h00;
              state_r <= ADCSQ_CONV;
            end
          end
        end
        ADCSQ_CONV: begin
          if (go_clear_sw) begin
            go_r    <= 1'b0;
            step_r  <= 5'h00;
            state_r <= ADCSQ_GAP;
          end else if (tad_tick) begin
            step_r <= step_r + 5'h01;
            if (conv_last) begin
              go_r    <= 1'b0;
              step_r  <= 5'h00;
              state_r <= ADCSQ_GAP;
            end
          end
        end
        ADCSQ_GAP: begin
          if (tad_tick) begin
            step_r <= step_r + 5'h01;
            if (step_r == 5'(POST_GAP_BITS - 1))
              state_r <= ADCSQ_IDLE;
          end
        end
        default: state_r <= ADCSQ_IDLE;
      endcase
    end
  end

  //------------------------------------------------------------
  // outputs and read path
  //------------------------------------------------------------
  logic [NUM_INPUTS-1:0] analog_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_pin
      // input gi goes digital once code exceeds all-analog by NUM_INPUTS-gi
      assign analog_nxt[gi] = ({1'b0, refpin_r.pin_analog_config} <=
                               5'(int'(PCFG_ALL_ANALOG) + NUM_INPUTS - gi - 1));
    end
  endgenerate

  always_comb begin
    case (wr_addr_r)
      ADDR_CHAN_CTRL:  rdata_nxt = {30'h0, go_r, mod_on_r};
      ADDR_REF_PIN:    rdata_nxt = {26'h0, refpin_r};
      ADDR_FMT_TIMING: rdata_nxt = {24'h0, fmt_r};
      ADDR_RES_HIGH:   rdata_nxt = {24'h0, result_r[15:8]};
      ADDR_RES_LOW:    rdata_nxt = {24'h0, result_r[7:0]};
      ADDR_STATUS:     rdata_nxt = {30'h0, irq_en_r, done_flag_r};
      default:         rdata_nxt = 32'h0;
    endcase
  end

  logic rd_ph_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_r       <= 1'b0;
      hrdata        <= 32'h0;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      neg_ref_ext   <= 1'b0;
      pos_ref_ext   <= 1'b0;
      pin_analog_en <= '0;
      sample_en     <= 1'b0;
      conv_irq      <= 1'b0;
    end else begin
      rd_ph_r       <= addr_ph & ~hwrite;
      hreadyout     <= ~(addr_ph & ~hwrite);
      hrdata        <= rd_ph_r ? rdata_nxt : 32'h0;
      neg_ref_ext   <= refpin_r.neg_ref_select;
      pos_ref_ext   <= refpin_r.pos_ref_select;
      pin_analog_en <= analog_nxt;
      sample_en     <= mod_on_r & ((state_r == ADCSQ_IDLE) | (state_r == ADCSQ_ACQ) |
                                   (state_r == ADCSQ_RC_HOLD));
      conv_irq      <= done_flag_r & irq_en_r;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  chk_done_clears_go: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_last |=> (!go_r && done_flag_r)) else $error("go not cleared at completion");
  chk_gap_after_conv: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_last |=> state_r == ADCSQ_GAP) else $error("no gap after conversion");
  chk_acq_zero_conv: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ADCSQ_IDLE && go_set_sw && !use_rc && acq_code == 3'h0)
    |=> state_r == ADCSQ_CONV) else $error("zero acquisition did not start conversion");
  chk_acq_inserted: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ADCSQ_IDLE && go_set_sw && !use_rc && acq_code != 3'h0)
    |=> state_r == ADCSQ_ACQ) else $error("acquisition not inserted");
  chk_rc_holdoff: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ADCSQ_IDLE && go_set_sw && use_rc) |=> (state_r == ADCSQ_RC_HOLD) [*4])
    else $error("rc holdoff too short");
  chk_abort_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ADCSQ_CONV && go_clear_sw) |=> $stable(result_r))
    else $error("abort changed result");
  chk_ref_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_refp && strap_done_r) |=> ##1 (neg_ref_ext == $past(hwdata[BIT_NEG_REF], 2)))
    else $error("neg ref mismatch");
  chk_pos_ref: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_refp && strap_done_r) |=> ##1 (pos_ref_ext == $past(hwdata[BIT_POS_REF], 2)))
    else $error("pos ref mismatch");
  chk_all_digital: assert property (@(posedge hclk) disable iff (!hresetn)
    refpin_r.pin_analog_config == 4'hF |=> pin_analog_en == '0)
    else $error("code F left an analog input");

endmodule : adcsq_top
